//--- verilog/spdl_pkg.sv
package spdl_pkg;

	// ****************************************************
	// register map
	// ****************************************************
	localparam logic [7:0] SPDL_OFF_CTRL = 8'h2a;
	localparam logic [7:0] SPDL_OFF_STATUS = 8'h2b;
	localparam logic [7:0] SPDL_OFF_DATA = 8'h2c;

	// ****************************************************
	// control and status fields
	// ****************************************************
	localparam int SPDL_CB_IRQ_EN = 7;
	localparam int SPDL_CB_ENABLE = 6;
	localparam int SPDL_CB_MASTER = 4;
	localparam int SPDL_CB_CPOL = 3;
	localparam int SPDL_CB_CPHA = 2;
	localparam int SPDL_CB_RATE = 0;
	localparam int SPDL_SB_DONE = 7;
	localparam int SPDL_SB_WRITE_COLLISION_FLAG = 6;
	localparam int SPDL_SB_MODE_FAULT_FLAG = 4;

	// ****************************************************
	// reset values and counts
	// ****************************************************
	localparam logic [7:0] SPDL_CTRL_RESET = 8'h00;
	localparam logic [7:0] SPDL_DATA_RESET = 8'h00;
	localparam logic [4:0] SPDL_LAST_EDGE = 5'h0f;
	localparam logic [3:0] SPDL_LAST_SAMPLE = 4'h7;
	// half sck period in mclk cycles minus one, per rate code
	localparam logic [4:0] SPDL_HALF_R0 = 5'h00;
	localparam logic [4:0] SPDL_HALF_R1 = 5'h01;
	localparam logic [4:0] SPDL_HALF_R2 = 5'h07;
	localparam logic [4:0] SPDL_HALF_R3 = 5'h0f;

	typedef enum logic [1:0] {
		SPDL_IDLE,
		SPDL_MASTER_RUN,
		SPDL_SLAVE_RUN
	} spdl_state_type;

endpackage : spdl_pkg

//--- verilog/spdl_core.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
module spdl_core
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	// low power
	input wire logic stop_mode,
	// interrupt request
	output logic irq,
	// serial clock pin
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	// master out pin
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	// master in pin
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	// slave select, active low
	input wire logic ss_n
);
	import spdl_pkg::*;

	// ****************************************************
	// state
	// ****************************************************
	typedef struct packed {
		spdl_pkg::spdl_state_type state;
		logic [7:0] ctrl;
		logic [7:0] shift;
		logic [7:0] rx_buf;
		logic out_bit;
		logic [4:0] edges;
		logic [3:0] samples;
		logic [4:0] div;
		logic sck;
		logic sck_prev;
		logic ss_prev;
		logic done_flag;
		logic write_collision_flag;
		logic mode_fault_flag;
		logic done_armed;
		logic write_collision_flag_armed;
		logic mode_fault_flag_armed;
		logic [7:0] rdata;
	} spdl_regs_type;

	spdl_regs_type r;
	spdl_regs_type next_r;

	function automatic logic [4:0] spdl_half_limit(input logic [1:0] rate);
		logic [4:0] lim;
		lim = SPDL_HALF_R0;
		unique case (rate)
			2'h0: lim = SPDL_HALF_R0;
			2'h1: lim = SPDL_HALF_R1;
			2'h2: lim = SPDL_HALF_R2;
			2'h3: lim = SPDL_HALF_R3;
		endcase
		return lim;
	endfunction : spdl_half_limit

	// ****************************************************
	// next state
	// ****************************************************
	logic data_wr;
	logic data_rd;
	logic ctrl_wr;
	logic status_rd;
	logic is_master;
	logic enabled;
	logic cpha;
	logic selected;
	logic busy;
	logic done_ok;
	logic tick;
	logic leading;
	logic sample_edge;
	logic sck_edge;
	logic complete;

	always_comb
	begin
		next_r = r;
		data_wr = wr_en && (addr == SPDL_OFF_DATA);
		data_rd = rd_en && (addr == SPDL_OFF_DATA);
		ctrl_wr = wr_en && (addr == SPDL_OFF_CTRL);
		status_rd = rd_en && (addr == SPDL_OFF_STATUS);
		is_master = r.ctrl[SPDL_CB_MASTER];
		enabled = r.ctrl[SPDL_CB_ENABLE];
		cpha = r.ctrl[SPDL_CB_CPHA];
		selected = enabled && !is_master && !ss_n;
		// with cpha clear the slave counts as busy whenever selected, so data writes collide
		busy = (r.state != SPDL_IDLE) || (selected && !cpha);
		done_ok = !r.done_flag || r.done_armed;
		tick = 1'b0;
		leading = 1'b0;
		sample_edge = 1'b0;
		sck_edge = 1'b0;
		complete = 1'b0;
		next_r.sck_prev = sck_in;
		next_r.ss_prev = ss_n;

		// register reads, answered one cycle later
		next_r.rdata = 8'h00;
		if (rd_en)
		begin
			unique case (addr)
				SPDL_OFF_CTRL: next_r.rdata = r.ctrl;
				SPDL_OFF_STATUS:
				begin
					next_r.rdata[SPDL_SB_DONE] = r.done_flag;
					next_r.rdata[SPDL_SB_WRITE_COLLISION_FLAG] = r.write_collision_flag;
					next_r.rdata[SPDL_SB_MODE_FAULT_FLAG] = r.mode_fault_flag;
				end
				SPDL_OFF_DATA: next_r.rdata = r.rx_buf;
				default: next_r.rdata = 8'h00;
			endcase
		end

		// status read arms the clearing sequences
		if (status_rd)
		begin
			next_r.done_armed = r.done_flag;
			next_r.write_collision_flag_armed = r.write_collision_flag;
			next_r.mode_fault_flag_armed = r.mode_fault_flag;
		end

		// data access finishes the sequence
		if (data_rd || data_wr)
		begin
			if (r.done_armed)
			begin
				next_r.done_flag = 1'b0;
				next_r.done_armed = 1'b0;
			end
			if (r.write_collision_flag_armed)
			begin
				next_r.write_collision_flag = 1'b0;
				next_r.write_collision_flag_armed = 1'b0;
			end
		end

		// data writes load the shifter directly
		if (data_wr)
		begin
			if (busy)
			begin
				next_r.write_collision_flag = 1'b1;
			end
			else if (is_master)
			begin
				if (enabled && done_ok)
				begin
					next_r.shift = wdata;
					next_r.out_bit = wdata[7];
					next_r.state = SPDL_MASTER_RUN;
					next_r.edges = 5'h00;
					next_r.div = 5'h00;
				end
			end
			else
			begin
				next_r.shift = wdata;
				next_r.out_bit = wdata[7];
			end
		end

		// control writes; enable and master held off during a fault
		if (ctrl_wr)
		begin
			next_r.ctrl = wdata;
			if (r.mode_fault_flag && !r.mode_fault_flag_armed)
			begin
				next_r.ctrl[SPDL_CB_ENABLE] = 1'b0;
				next_r.ctrl[SPDL_CB_MASTER] = 1'b0;
			end
			if (r.mode_fault_flag_armed)
			begin
				next_r.mode_fault_flag = 1'b0;
				next_r.mode_fault_flag_armed = 1'b0;
			end
		end

		// master byte engine, paced by the baud divider
		if (r.state == SPDL_MASTER_RUN)
		begin
			// stop freezes everything in place until released
			if (!stop_mode)
			begin
				// divider restarts on every start, so the first
				// half period is always a full one
				if (r.div == spdl_half_limit(r.ctrl[1:0]))
				begin
					tick = 1'b1;
					next_r.div = 5'h00;
				end
				else
				begin
					next_r.div = r.div + 5'h01;
				end
			end
			if (tick)
			begin
				leading = !r.edges[0];
				sample_edge = leading ^ cpha;
				next_r.sck = !r.sck;
				next_r.edges = r.edges + 5'h01;
				if (sample_edge)
				begin
					next_r.shift = {r.shift[6:0], miso_in};
				end
				else
				begin
					next_r.out_bit = r.shift[7];
				end
				// sixteen edges is eight sck periods
				if (r.edges == SPDL_LAST_EDGE)
				begin
					complete = 1'b1;
					next_r.state = SPDL_IDLE;
				end
			end
		end
		else if (is_master)
		begin
			next_r.sck = r.ctrl[SPDL_CB_CPOL];
		end

		// slave byte engine, clocked by the far master
		// sck_prev resets low, so a clock idling high shows one
		// false edge after reset; harmless, nothing acts unselected
		sck_edge = (sck_in != r.sck_prev);
		if (!is_master)
		begin
			// runs from the pins alone, so stop has no effect here
			if (!selected)
			begin
				if (r.state == SPDL_SLAVE_RUN)
				begin
					next_r.state = SPDL_IDLE;
				end
			end
			else if (r.state == SPDL_IDLE && !cpha && r.ss_prev)
			begin
				// unwritten shifter still holds the last byte
				next_r.out_bit = r.shift[7];
				next_r.state = SPDL_SLAVE_RUN;
				next_r.samples = 4'h0;
			end
			else if (sck_edge && (r.state == SPDL_SLAVE_RUN || cpha))
			begin
				leading = (r.sck_prev == r.ctrl[SPDL_CB_CPOL]);
				sample_edge = leading ^ cpha;
				if (r.state == SPDL_IDLE)
				begin
					next_r.state = SPDL_SLAVE_RUN;
					next_r.samples = 4'h0;
				end
				if (sample_edge)
				begin
					next_r.shift = {r.shift[6:0], mosi_in};
					next_r.samples = r.samples + 4'h1;
					if (r.samples == SPDL_LAST_SAMPLE)
					begin
						complete = 1'b1;
						next_r.state = SPDL_IDLE;
					end
				end
				else
				begin
					next_r.out_bit = r.shift[7];
				end
			end
		end

		// byte done: flag and buffer move in the same cycle
		// set wins over a clear in this cycle, but the clear still
		// lets the new byte into the buffer
		if (complete)
		begin
			if (!next_r.done_flag)
			begin
				next_r.rx_buf = next_r.shift;
			end
			next_r.done_flag = 1'b1;
			next_r.done_armed = 1'b0;
		end

		// master pulled low by another master
		// outranks any start or control write of this cycle
		if (enabled && is_master && !ss_n)
		begin
			next_r.mode_fault_flag = 1'b1;
			next_r.mode_fault_flag_armed = 1'b0;
			next_r.ctrl[SPDL_CB_ENABLE] = 1'b0;
			next_r.ctrl[SPDL_CB_MASTER] = 1'b0;
			next_r.state = SPDL_IDLE;
		end
	end

	// ****************************************************
	// registers
	// ****************************************************
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			// reset, also the exit from stop by reset
			r <= '{state: SPDL_IDLE, ctrl: SPDL_CTRL_RESET,
				shift: SPDL_DATA_RESET, rx_buf: SPDL_DATA_RESET,
				rdata: SPDL_DATA_RESET, default: '0};
		end
		else
		begin
			r <= next_r;
		end
	end

	// ****************************************************
	// outputs
	// ****************************************************
	// mclk keeps running in wait, so the request can wake the cpu
	assign irq = r.ctrl[SPDL_CB_IRQ_EN] && (r.done_flag || r.mode_fault_flag);
	assign rdata = r.rdata;
	assign sck_out = r.sck;
	assign mosi_out = r.out_bit;
	assign miso_out = r.out_bit;
	assign sck_oe = r.ctrl[SPDL_CB_ENABLE] && r.ctrl[SPDL_CB_MASTER];
	assign mosi_oe = r.ctrl[SPDL_CB_ENABLE] && r.ctrl[SPDL_CB_MASTER];
	// only one selected slave may drive, the master must ensure it
	assign miso_oe = r.ctrl[SPDL_CB_ENABLE] && !r.ctrl[SPDL_CB_MASTER]
		&& !ss_n;

endmodule : spdl_core

//--- test/spdl_core_properties.sv
`timescale 1ns/1ns
module spdl_core_properties
	import spdl_pkg::*;
(
	// clock, reset, register port
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rdata,
	// low power, irq, pins
	input wire logic stop_mode,
	input wire logic irq,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic mosi_oe,
	input wire logic miso_oe,
	input wire logic ss_n
);
	logic [3:0] tog;
	logic sck_q;

	// ****************************************
	// edge count: sixteen wraps to zero
	// ****************************************
	always_ff @(posedge mclk)
	begin
		sck_q <= sck_out;
		if (!rst_b || !sck_oe)
			tog <= 4'h0;
		else if (sck_out != sck_q)
			tog <= tog + 4'h1;
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
		else $error("rdata idle");
	a_miso_select: assert property (miso_oe |-> !ss_n && !sck_oe)
		else $error("miso drive");
	a_drive_pair: assert property (mosi_oe == sck_oe)
		else $error("oe pair");
	a_fault_drop: assert property (sck_oe && !ss_n |-> ##[1:3] !sck_oe)
		else $error("mode fault");
	a_slave_nostart: assert property (
		wr_en && addr == SPDL_OFF_DATA && !sck_oe |=> $stable(sck_out) [*2])
		else $error("slave start");
	a_stop_freeze: assert property (
		sck_oe && stop_mode && $past(stop_mode) && $past(stop_mode, 2)
		|-> sck_out == sck_q) else $error("stop freeze");
	a_edge_pace: assert property (
		sck_oe && tog != 4'h0 && sck_out == sck_q && !stop_mode
		|-> ##[1:17] (sck_out != sck_q || stop_mode || !sck_oe))
		else $error("edge count");
	a_irq_cause: assert property (
		$rose(irq) |-> $past(wr_en) || $past(sck_oe) || !$past(ss_n))
		else $error("irq cause");

	cover property ($rose(irq));
	cover property (sck_oe && stop_mode);
	cover property (miso_oe && !ss_n);
endmodule : spdl_core_properties

bind spdl_core spdl_core_properties spdl_core_properties_i (.mclk, .rst_b,
	.addr, .wr_en, .rd_en, .rdata, .stop_mode, .irq, .sck_out, .sck_oe,
	.mosi_oe, .miso_oe, .ss_n);

//--- test/spdl_far_slave.sv
`timescale 1ns/1ns
module spdl_far_slave
(
	// serial pins
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel_n,
	output logic miso,
	// phase and data
	input wire logic cpha,
	input wire logic [7:0] reply,
	output logic [7:0] got
);
	logic [7:0] sh;

	assign got = sh;
	initial miso = 1'h0;

	// ****************************************
	// sole slave on miso, one byte a select
	// ****************************************
	always @(negedge sel_n)
	begin
		sh = reply;
		if (!cpha)
			miso = sh[7];
	end
	always @(posedge sck)
		if (!sel_n && cpha)
			miso = sh[7];
		else if (!sel_n)
			sh = {sh[6:0], mosi};
	always @(negedge sck)
		if (!sel_n && cpha)
			sh = {sh[6:0], mosi};
		else if (!sel_n)
			miso = sh[7];
	// released line must not keep the last bit
	always @(posedge sel_n)
		miso = ~miso;
endmodule : spdl_far_slave

//--- test/testbench.sv
`timescale 1ns/1ns
module testbench;
	import spdl_pkg::*;
	logic mclk, rst_b, wr_en, rd_en, stop_mode, ss_n, irq;
	logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
	logic m_sck, m_mosi, far_sel_n, far_miso;
	logic [7:0] addr, wdata, rdata, rep, got, tx, v, cf;
	logic [7:0] rx_q[$];
	integer seed = 97;
	integer error_cnt = 0;
	integer n_tests = 0;
	wire logic sck_w = sck_oe ? sck_out : m_sck;
	wire logic mosi_w = mosi_oe ? mosi_out : m_mosi;
	wire logic miso_w = miso_oe ? miso_out : far_miso;

	spdl_core spdl_core_i (.mclk, .rst_b, .addr, .wdata, .wr_en, .rd_en,
		.rdata, .stop_mode, .irq, .sck_in(sck_w), .sck_out, .sck_oe,
		.mosi_in(mosi_w), .mosi_out, .mosi_oe, .miso_in(miso_w),
		.miso_out, .miso_oe, .ss_n);
	spdl_far_slave spdl_far_slave_i (.sck(sck_w), .mosi(mosi_w),
		.sel_n(far_sel_n), .miso(far_miso), .cpha(cf[SPDL_CB_CPHA]),
		.reply(rep), .got);

	task automatic summarize;
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input string n, input logic [7:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'h1;
		@(posedge mclk);
		wr_en <= 1'h0;
		#1;
	endtask : wr

	task automatic rc(input string n, input logic [7:0] a, e);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge mclk);
		rd_en <= 1'h0;
		#1;
		chk(n, e, rdata);
	endtask : rc

	task automatic do_reset;
		rst_b <= 1'h0;
		cyc(10);
		rst_b <= 1'h1;
		cyc(1);
	endtask : do_reset

	// ****************************************
	// bench as far master, ph is cpha, m_sck idles at cpol
	// ****************************************
	task automatic xfer(input logic [7:0] m, input bit ph,
		output logic [7:0] s);
		ss_n <= 1'h0;
		cyc(4);
		for (int i = 7; i >= 0; i--)
		begin
			if (ph)
				m_sck <= ~m_sck;
			m_mosi <= m[i];
			cyc(4);
			s[i] = miso_w;
			m_sck <= ~m_sck;
			cyc(4);
			if (!ph)
				m_sck <= ~m_sck;
		end
		cyc(4);
		ss_n <= 1'h1;
		cyc(4);
	endtask : xfer

	initial
	begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end

	initial
	begin
		#200000;
		error_cnt++;
		summarize();
	end

	initial
	begin
		{rst_b, wr_en, rd_en, stop_mode, m_sck, m_mosi} = 6'h00;
		{ss_n, far_sel_n} = 2'h3;
		{addr, wdata, rep, cf} = 32'h0;
		do_reset();
		rc("ctrl", SPDL_OFF_CTRL, SPDL_CTRL_RESET);
		rc("data", SPDL_OFF_DATA, SPDL_DATA_RESET);
		wr(8'h3f, 8'h5a);
		rc("unmapped", 8'h3f, 8'h00);
		// every rate code with both phases
		for (int k = 0; k < 8; k++)
		begin
			cf = 8'hd0 | 8'(k);
			wr(SPDL_OFF_CTRL, cf);
			tx = 8'($random(seed));
			rep = 8'($random(seed));
			far_sel_n <= 1'h0;
			wr(SPDL_OFF_DATA, tx);
			wr(SPDL_OFF_DATA, ~tx);
			rc("write_collision_flag", SPDL_OFF_STATUS, 8'h40);
			stop_mode <= 1'h1;
			cyc(20);
			stop_mode <= 1'h0;
			for (int i = 0; i < 800 && irq !== 1'h1; i++)
				@(posedge mclk);
			#1;
			far_sel_n <= 1'h1;
			chk("irq", 8'h01, {7'h0, irq});
			rc("status", SPDL_OFF_STATUS, 8'hc0);
			rc("rx", SPDL_OFF_DATA, rep);
			chk("far rx", tx, got);
			rc("cleared", SPDL_OFF_STATUS, 8'h00);
		end
		wr(SPDL_OFF_CTRL, 8'h40);
		tx = 8'($random(seed));
		wr(SPDL_OFF_DATA, tx);
		cyc(3);
		// second byte with cpol and cpha set, during stop
		for (int k = 0; k < 2; k++)
		begin
			rx_q.push_back(8'($random(seed)));
			stop_mode <= 1'(k);
			m_sck <= 1'(k);
			wr(SPDL_OFF_CTRL, 8'h40 | 8'(k * 12));
			xfer(rx_q[k], 1'(k), v);
			chk("slave tx", k ? rx_q[0] : tx, v);
		end
		stop_mode <= 1'h0;
		m_sck <= 1'h0;
		rc("overrun", SPDL_OFF_STATUS, 8'h80);
		rc("slave rx", SPDL_OFF_DATA, rx_q[0]);
		wr(SPDL_OFF_CTRL, 8'h53);
		wr(SPDL_OFF_DATA, tx);
		cyc(5);
		do_reset();
		rc("ctrl", SPDL_OFF_CTRL, SPDL_CTRL_RESET);
		rc("status", SPDL_OFF_STATUS, 8'h00);
		wr(SPDL_OFF_CTRL, 8'hd0);
		ss_n <= 1'h0;
		cyc(3);
		ss_n <= 1'h1;
		chk("fault irq", 8'h01, {7'h0, irq});
		rc("fault", SPDL_OFF_STATUS, 8'h10);
		rc("ctrl", SPDL_OFF_CTRL, 8'h80);
		summarize();
	end
endmodule : testbench
